// ### uart_far_end.sv
// far-end serial partner: sends frames to the block and decodes its output
`timescale 1ns/1ps
module uart_far_end #(parameter int BC = 16) (
   input wire logic clock_i,
   input wire logic tx_line_i,
   output logic rx_line_o,
   output logic [7:0] last_word_o,
   output int words_o
);
   logic [7:0] sh;
   initial begin
      rx_line_o = 1'b1;
      last_word_o = 8'h00;
      words_o = 0;
   end
   task automatic put_bit(input logic b);
      rx_line_o <= b;
      repeat (BC) @(posedge clock_i);
   endtask
   // one frame, lsb first, optional bad parity or missing stop
   task automatic send_word(input logic [7:0] d, input logic po, odd, bad, stop_ok);
      @(posedge clock_i);
      put_bit(1'b0);
      for (int i = 0; i < 8; i++) begin
         put_bit(d[i]);
      end
      if (po) begin
         put_bit(^d ^ odd ^ bad);
      end
      put_bit(stop_ok);
      put_bit(1'b1);
   endtask
   // low glitch shorter than half a bit
   task automatic glitch();
      @(posedge clock_i);
      rx_line_o <= 1'b0;
      repeat (3) @(posedge clock_i);
      rx_line_o <= 1'b1;
   endtask
   always begin
      @(negedge tx_line_i);
      repeat (BC / 2) @(posedge clock_i);
      for (int i = 0; i < 8; i++) begin
         repeat (BC) @(posedge clock_i);
         #1;
         sh[i] = tx_line_i;
      end
      repeat (BC) @(posedge clock_i);
      last_word_o = sh;
      words_o++;
   end
endmodule

// ### uart_pkg.sv
// shared constants and carrier types for the uart receive/transmit status block
package uart_pkg;
   // -----------------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------------
   localparam int CLOCK_HZ = 50000000;
   localparam int BAUD_DEFAULT = 9600;
   localparam int BIT_CYCLES_DEFAULT = CLOCK_HZ / BAUD_DEFAULT;
   localparam int DIV_W = 16;
   // -----------------------------------------------------------------------
   // status field positions
   // -----------------------------------------------------------------------
   localparam int RXS_WAITING = 0;
   localparam int RXS_BUSY = 1;
   localparam int RXS_FRAMING = 3;
   localparam int RXS_PARITY = 4;
   localparam int RXS_START = 5;
   localparam int TXS_OCCUPIED = 0;
   localparam int TXS_BUSY = 1;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [3:0] DATA_BITS = 4'h8;
   localparam logic [3:0] HALF_BIT_DIV = 4'h2;

   typedef struct packed {
      logic enable_rx;
      logic enable_tx;
      logic parity_enable;
      logic parity_odd;
   } uart_config_t;

   typedef struct packed {
      logic start_fault;
      logic parity_fault;
      logic framing_fault;
      logic overrun;
      logic rx_busy;
      logic word_waiting;
   } rx_status_t;
endpackage

// ### uart_status_core.sv
// uart receive status, data handoff and transmit holding logic
// Function
// - data transfer pulses receive interrupt, flags data
// - word waiting flag reads one when unread
// - unread word overwritten sets overrun flag
// - status write of any value clears overrun
// - start fault flag refreshed at transfer
// - parity fault computed, refreshed at transfer
// - missing stop bit sets framing fault
// - holding to shifter move pulses transmit interrupt
// - holding occupied zero means writable
// - stop bit copies shifter into data register
// - data register read clears waiting flag
// - load holding only after previous sent
// - characters shifted least significant first
`timescale 1ns/1ps
module uart_status_core (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire uart_pkg::uart_config_t config_i,
   input wire logic [uart_pkg::DIV_W-1:0] bit_cycles_i,
   input wire logic rx_line_i,
   output logic tx_line_o,
   input wire logic rx_data_read_i,
   input wire logic rx_status_write_i,
   input wire logic tx_write_i,
   input wire logic [7:0] tx_data_i,
   output logic [7:0] rx_data_reg,
   output logic [7:0] rx_status_reg,
   output logic [7:0] tx_status_reg,
   output logic rx_irq_o,
   output logic tx_irq_o
);
   // -----------------------------------------------------------------------
   // input synchroniser
   // -----------------------------------------------------------------------
   logic [2:0] rx_sync;
   logic rx_level;
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         rx_sync <= 3'h7;
         rx_level <= 1'b1;
      end else begin
         rx_sync <= {rx_sync[1:0], rx_line_i};
         if (rx_sync[1] == rx_sync[2]) begin
            rx_level <= rx_sync[2];
         end
      end
   end

   // -----------------------------------------------------------------------
   // receiver
   // -----------------------------------------------------------------------
   typedef enum logic [4:0] {
      RX_IDLE = 5'b00001,
      RX_START = 5'b00010,
      RX_DATA = 5'b00100,
      RX_PARITY = 5'b01000,
      RX_STOP = 5'b10000
   } rx_state_t;
   rx_state_t rx_state;
   logic rx_half;
   logic rx_full;
   logic rx_restart;
   logic [7:0] rx_shift;
   logic [3:0] rx_count;
   logic rx_par_bit;
   logic rx_transfer;
   logic rx_stop_ok;
   logic rx_start_bad;
   logic word_waiting;
   logic overrun;
   logic start_fault;
   logic parity_fault;
   logic framing_fault;

   function automatic logic parity_of(input logic [7:0] d, input logic odd);
      parity_of = (^d) ^ odd;
   endfunction

   assign rx_restart = (rx_state == RX_IDLE);

   uart_tick rx_tick (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .restart_i(rx_restart),
      .bit_cycles_i(bit_cycles_i),
      .half_o(rx_half),
      .full_o(rx_full)
   );

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         rx_state <= RX_IDLE;
         rx_shift <= 8'h00;
         rx_count <= 4'h0;
         rx_par_bit <= 1'b0;
         rx_transfer <= 1'b0;
         rx_stop_ok <= 1'b0;
         rx_start_bad <= 1'b0;
      end else begin
         rx_transfer <= 1'b0;
         if (rx_transfer) begin
            rx_start_bad <= 1'b0;
         end
         case (rx_state)
            RX_IDLE: begin
               rx_count <= 4'h0;
               if (config_i.enable_rx && !rx_level) begin
                  rx_state <= RX_START;
               end
            end
            RX_START: begin
               if (rx_half && rx_level) begin
                  rx_start_bad <= 1'b1;
                  rx_state <= RX_IDLE;
               end
               if (rx_full) begin
                  rx_state <= RX_DATA;
               end
            end
            RX_DATA: begin
               if (rx_half) begin
                  rx_shift <= {rx_level, rx_shift[7:1]};
                  rx_count <= rx_count + 4'h1;
               end
               if (rx_full && rx_count == uart_pkg::DATA_BITS) begin
                  rx_state <= config_i.parity_enable ? RX_PARITY : RX_STOP;
               end
            end
            RX_PARITY: begin
               if (rx_half) begin
                  rx_par_bit <= rx_level;
               end
               if (rx_full) begin
                  rx_state <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (rx_half) begin
                  rx_stop_ok <= rx_level;
                  rx_transfer <= 1'b1;
                  rx_state <= RX_IDLE;
               end
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   // data register takes the word on the stop bit
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         rx_data_reg <= uart_pkg::DATA_RESET;
      end else if (rx_transfer) begin
         rx_data_reg <= rx_shift;
      end
   end

   // waiting flag: transfer wins over a simultaneous read
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         word_waiting <= 1'b0;
      end else if (rx_transfer) begin
         word_waiting <= 1'b1;
      end else if (rx_data_read_i) begin
         word_waiting <= 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         overrun <= 1'b0;
      end else if (rx_transfer && word_waiting && !rx_data_read_i) begin
         overrun <= 1'b1;
      end else if (rx_status_write_i) begin
         overrun <= 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         start_fault <= 1'b0;
         parity_fault <= 1'b0;
         framing_fault <= 1'b0;
      end else if (rx_transfer) begin
         start_fault <= rx_start_bad;
         parity_fault <= config_i.parity_enable &&
                         (rx_par_bit != parity_of(rx_shift, config_i.parity_odd));
         framing_fault <= !rx_stop_ok;
      end
   end

   assign rx_irq_o = rx_transfer;
   assign rx_status_reg = {2'b00, start_fault, parity_fault, framing_fault, overrun,
                           (rx_state != RX_IDLE), word_waiting};

   // -----------------------------------------------------------------------
   // transmitter
   // -----------------------------------------------------------------------
   logic [7:0] tx_holding_reg;
   logic tx_holding_occupied;
   logic [10:0] tx_shift;
   logic [3:0] tx_left;
   logic tx_load;
   logic tx_tick;
   logic tx_busy;

   assign tx_busy = (tx_left != 4'h0);
   assign tx_load = config_i.enable_tx && tx_holding_occupied && !tx_busy;

   uart_tick tx_div (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .restart_i(tx_load),
      .bit_cycles_i(bit_cycles_i),
      .half_o(),
      .full_o(tx_tick)
   );

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         tx_holding_reg <= uart_pkg::DATA_RESET;
         tx_holding_occupied <= 1'b0;
      end else if (tx_write_i) begin
         tx_holding_reg <= tx_data_i;
         tx_holding_occupied <= 1'b1;
      end else if (tx_load) begin
         tx_holding_occupied <= 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         tx_shift <= 11'h7FF;
         tx_left <= 4'h0;
      end else if (tx_load) begin
         tx_shift <= {1'b1, parity_of(tx_holding_reg, config_i.parity_odd),
                      tx_holding_reg, 1'b0};
         tx_left <= config_i.parity_enable ? 4'hB : 4'hA;
      end else if (tx_tick && tx_busy) begin
         tx_shift <= {1'b1, tx_shift[10:1]};
         tx_left <= tx_left - 4'h1;
      end
   end

   // stop bit takes the parity slot, forced high, when parity is off
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         tx_line_o <= 1'b1;
      end else if (tx_busy && !config_i.parity_enable && tx_left == 4'h1) begin
         tx_line_o <= 1'b1;
      end else begin
         tx_line_o <= tx_busy ? tx_shift[0] : 1'b1;
      end
   end

   assign tx_irq_o = tx_load;
   assign tx_status_reg = {6'h00, tx_busy, tx_holding_occupied};

   // -----------------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------------
   rx_irq_flag_a: assert property (@(posedge clock_i) disable iff (srst_i)
      rx_irq_o |=> word_waiting) else $error("rx irq without waiting flag");
   read_clears_a: assert property (@(posedge clock_i) disable iff (srst_i)
      rx_data_read_i && !rx_transfer |=> !word_waiting) else $error("read kept flag");
   overrun_set_a: assert property (@(posedge clock_i) disable iff (srst_i)
      rx_transfer && word_waiting && !rx_data_read_i |=> overrun) else $error("no overrun");
   overrun_clear_a: assert property (@(posedge clock_i) disable iff (srst_i)
      rx_status_write_i && !rx_transfer |=> !overrun) else $error("overrun kept");
   overrun_hold_a: assert property (@(posedge clock_i) disable iff (srst_i)
      overrun && !rx_status_write_i |=> overrun) else $error("overrun dropped");
   data_copy_a: assert property (@(posedge clock_i) disable iff (srst_i)
      rx_transfer |=> rx_data_reg == $past(rx_shift)) else $error("data not copied");
   errors_stable_a: assert property (@(posedge clock_i) disable iff (srst_i)
      !rx_transfer |=> $stable({start_fault, parity_fault, framing_fault}))
      else $error("error flag moved");
   start_abort_a: assert property (@(posedge clock_i) disable iff (srst_i)
      rx_state == RX_START && rx_half && rx_level |=> rx_state == RX_IDLE && rx_start_bad)
      else $error("bad start kept");
   tx_irq_clear_a: assert property (@(posedge clock_i) disable iff (srst_i)
      tx_irq_o && !tx_write_i |=> !tx_holding_occupied && tx_busy)
      else $error("tx load wrong");
   tx_wait_a: assert property (@(posedge clock_i) disable iff (srst_i)
      $fell(tx_holding_occupied) |-> !$past(tx_busy)) else $error("load while sending");
   rx_word_c: cover property (@(posedge clock_i) rx_transfer);
   overrun_c: cover property (@(posedge clock_i) rx_transfer && word_waiting);
   start_fault_c: cover property (@(posedge clock_i) rx_transfer && rx_start_bad);
   tx_load_c: cover property (@(posedge clock_i) tx_load);
endmodule

// ### uart_status_core_tb_top.sv
// self-checking bench for the uart status and handoff block
`timescale 1ns/1ps
module uart_status_core_tb_top;
   localparam int BC = 16;
   logic clock_i = 1'b0;
   logic srst_i = 1'b1;
   uart_pkg::uart_config_t cfg = '{1'b1, 1'b1, 1'b0, 1'b0};
   logic rx_line, tx_line, rd = 1'b0, sw = 1'b0, tw = 1'b0, rx_irq_o, tx_irq_o;
   logic [7:0] td = 8'h00, rx_data, rx_sta, tx_sta, far_word;
   int far_words, failures = 0, num_checks = 0;
   always #10 clock_i = ~clock_i;
   uart_status_core dut (.clock_i(clock_i), .srst_i(srst_i), .config_i(cfg),
      .bit_cycles_i(16'h0010), .rx_line_i(rx_line), .tx_line_o(tx_line),
      .rx_data_read_i(rd), .rx_status_write_i(sw), .tx_write_i(tw), .tx_data_i(td),
      .rx_data_reg(rx_data), .rx_status_reg(rx_sta), .tx_status_reg(tx_sta),
      .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o));
   uart_far_end #(.BC(BC)) far (.clock_i(clock_i), .tx_line_i(tx_line),
      .rx_line_o(rx_line), .last_word_o(far_word), .words_o(far_words));
   // ------------------------------
   // helpers
   // ------------------------------
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      if (failures == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic wait_irq(input bit tx, input int lim);
      for (int i = 0; i <= lim; i++) begin
         @(posedge clock_i);
         #1;
         if ((tx ? tx_irq_o : rx_irq_o) === 1'b1) return;
      end
      failures++;
      report_and_stop();
   endtask
   // one-cycle strobe: 0 data read, 1 status write, 2 holding write
   task automatic pulse(input int which, input logic [7:0] d);
      @(posedge clock_i);
      rd <= (which == 0);
      sw <= (which == 1);
      tw <= (which == 2);
      td <= d;
      @(posedge clock_i);
      rd <= 1'b0;
      sw <= 1'b0;
      tw <= 1'b0;
      #1;
   endtask
   task automatic rx_word(input logic [7:0] d, input logic po, bad, stop_ok);
      fork
         far.send_word(d, po, cfg.parity_odd, bad, stop_ok);
         begin
            repeat (BC) @(posedge clock_i);
            #1;
            check("rx busy", rx_sta & 8'h02, 8'h02);
            wait_irq(1'b0, 12 * BC);
            @(posedge clock_i);
            #1;
            check("rx irq width", {7'h00, rx_irq_o}, 8'h00);
         end
      join
      #1;
   endtask
   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic sc_rx_basic();
      rx_word(8'ha5, 1'b0, 1'b0, 1'b1);
      check("rx status", rx_sta, 8'h01);
      check("rx data", rx_data, 8'ha5);
      pulse(0, 8'h00);
      check("rx status read", rx_sta, 8'h00);
   endtask
   task automatic sc_overrun();
      rx_word(8'h3c, 1'b0, 1'b0, 1'b1);
      rx_word(8'hc3, 1'b0, 1'b0, 1'b1);
      check("overrun data", rx_data, 8'hc3);
      check("overrun status", rx_sta, 8'h05);
      pulse(0, 8'h00);
      check("overrun held", rx_sta, 8'h04);
      pulse(1, 8'h00);
      check("overrun cleared", rx_sta, 8'h00);
   endtask
   task automatic sc_parity();
      for (int m = 0; m < 4; m++) begin
         @(posedge clock_i);
         cfg.parity_enable <= 1'b1;
         cfg.parity_odd <= m[1];
         #1;
         rx_word(8'h5a ^ m[7:0], 1'b1, m[0], 1'b1);
         check("parity status", rx_sta, {3'h0, m[0], 4'h1});
         pulse(0, 8'h00);
      end
      @(posedge clock_i);
      cfg.parity_enable <= 1'b0;
   endtask
   task automatic sc_framing();
      rx_word(8'h81, 1'b0, 1'b0, 1'b0);
      check("framing status", rx_sta, 8'h09);
      pulse(0, 8'h00);
      pulse(1, 8'h00);
   endtask
   task automatic sc_start_fault();
      int hits = 0;
      far.glitch();
      repeat (3 * BC) begin
         @(posedge clock_i);
         #1;
         hits += (rx_irq_o !== 1'b0);
      end
      check("glitch transfers", hits[7:0], 8'h00);
      rx_word(8'h42, 1'b0, 1'b0, 1'b1);
      check("after glitch", rx_sta, 8'h21);
      check("after glitch data", rx_data, 8'h42);
      pulse(0, 8'h00);
   endtask
   task automatic sc_tx();
      int n = 0;
      pulse(2, 8'h96);
      check("tx irq idle", {7'h00, tx_irq_o}, 8'h01);
      @(posedge clock_i);
      #1;
      check("tx occupied idle", tx_sta, 8'h02);
      pulse(2, 8'h6b);
      check("tx occupied busy", tx_sta, 8'h03);
      check("tx irq busy", {7'h00, tx_irq_o}, 8'h00);
      wait_irq(1'b1, 12 * BC);
      check("first word out", far_word, 8'h96);
      while (tx_sta[uart_pkg::TXS_OCCUPIED] !== 1'b0 && n < 4) begin
         @(posedge clock_i);
         #1;
         n++;
      end
      check("tx occupied after load", tx_sta, 8'h02);
      n = 0;
      while (far_words < 2 && n < 12 * BC) begin
         @(posedge clock_i);
         n++;
      end
      check("far words", far_words[7:0], 8'h02);
      check("second word out", far_word, 8'h6b);
   endtask
   task automatic sc_enables();
      int hits = 0;
      @(posedge clock_i);
      cfg.enable_rx <= 1'b0;
      cfg.enable_tx <= 1'b0;
      pulse(2, 8'h17);
      fork
         far.send_word(8'h99, 1'b0, 1'b0, 1'b0, 1'b1);
         repeat (12 * BC) begin
            @(posedge clock_i);
            #1;
            hits += (rx_irq_o !== 1'b0) + (tx_irq_o !== 1'b0);
         end
      join
      check("disabled events", hits[7:0], 8'h00);
      check("disabled tx status", tx_sta, 8'h01);
      @(posedge clock_i);
      cfg.enable_rx <= 1'b1;
      cfg.enable_tx <= 1'b1;
      #1;
      check("enable load irq", {7'h00, tx_irq_o}, 8'h01);
   endtask
   initial begin
      repeat (8) @(posedge clock_i);
      #1;
      check("reset rx status", rx_sta, uart_pkg::STATUS_RESET);
      check("reset tx status", tx_sta, uart_pkg::STATUS_RESET);
      check("reset data", rx_data, uart_pkg::DATA_RESET);
      check("idle line", {7'h00, tx_line}, 8'h01);
      @(posedge clock_i);
      srst_i <= 1'b0;
      sc_rx_basic();
      sc_overrun();
      sc_parity();
      sc_framing();
      sc_start_fault();
      sc_tx();
      sc_enables();
      report_and_stop();
   end
endmodule

// ### uart_tick.sv
// baud tick divider producing bit and half bit enable pulses
`timescale 1ns/1ps
module uart_tick (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic restart_i,
   input wire logic [uart_pkg::DIV_W-1:0] bit_cycles_i,
   output logic half_o,
   output logic full_o
);
   logic [uart_pkg::DIV_W-1:0] count;
   logic [uart_pkg::DIV_W-1:0] half_point;

   assign half_point = bit_cycles_i >> 1;
   assign half_o = (count == half_point);
   assign full_o = (count == bit_cycles_i - 16'h0001);

   always_ff @(posedge clock_i) begin
      if (srst_i || restart_i || full_o) begin
         count <= 16'h0000;
      end else begin
         count <= count + 16'h0001;
      end
   end
endmodule
